//--- rtl/aoc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "aoc_regs.svh"
// Overview of operation
// - High format select gives two's complement
// - Output enable low drives except in full power-down, high floats
// - Stabiliser select high re-times clock falling edge
// - Full power-down stops and clears the pipeline and the output buffer
// - Partial power-down stops taking new samples
// - Twelve-bit word, MSB on top bit
// - Result appears four and half cycles later
module aoc_top
    import aoc_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    input  wire logic                    convert_clock,
    input  wire logic                    output_enable_b,
    input  wire logic                    code_format_select,
    input  wire logic                    duty_cycle_stabiliser,
    input  wire logic                    full_power_down,
    input  wire logic                    partial_power_down,
    input  wire logic [`AOC_RAW_W-1:0]   quant_code,
    output logic      [`AOC_DATA_W-1:0]  sample_bits,
    output logic                         over_range_flag,
    output logic                         data_oe,
    output logic                         sample_valid,
    input  wire logic                    sample_ready,
    output logic                         overrun,
    output aoc_pwr_t                     power_state,
    output logic                         stabiliser_active
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [`AOC_PIN_N-1:0] pin_s1;     // First stage, read by second only
    logic [`AOC_PIN_N-1:0] pin_s2;     // Second stage
    logic [`AOC_PIN_N-1:0] pin_s3;     // Third stage
    logic [`AOC_PIN_N-1:0] pin;        // Level once second and third agree
    logic [`AOC_PIN_N-1:0] next_pin;   // Filtered next value
    wire  [`AOC_PIN_N-1:0] pin_raw = {partial_power_down, full_power_down,
                                      duty_cycle_stabiliser, code_format_select,
                                      output_enable_b, convert_clock};

    assign next_pin = (pin_s2 & pin_s3) | (pin & (pin_s2 | pin_s3));

    // Four flip-flops per pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1 <= `AOC_PIN_RST;
            pin_s2 <= `AOC_PIN_RST;
            pin_s3 <= `AOC_PIN_RST;
            pin    <= `AOC_PIN_RST;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin    <= next_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Static controls
    wire conv_lvl = pin[`AOC_PIN_CLK];   // Filtered convert clock
    wire oe_b     = pin[`AOC_PIN_OE_B];  // Tri-state request
    wire fmt_sel  = pin[`AOC_PIN_FMT];   // Two's complement select
    wire dcs_sel  = pin[`AOC_PIN_DCS];   // Stabiliser select
    wire std_pd   = pin[`AOC_PIN_FPD];   // Full power-down
    wire quasi_pd = pin[`AOC_PIN_PPD];   // Partial power-down

    // Power state, full power-down first
    // full beats partial
    assign power_state = std_pd ? AOC_PWR_STD : (quasi_pd ? AOC_PWR_QUASI : AOC_PWR_RUN);

    // Output drivers
    // low enable drives pins unless in full power-down
    assign data_oe = !oe_b && (power_state != AOC_PWR_STD);

    ////////////////////////////////////////////////////////////////////////
    // Convert clock edges and stabiliser
    logic                  conv_prev;  // Convert level last cycle
    logic [`AOC_CNT_W-1:0] since_rise; // Cycles since last rising edge
    logic [`AOC_CNT_W-1:0] period;     // Last measured period
    wire                   rise      = conv_lvl & ~conv_prev;
    wire                   real_fall = ~conv_lvl & conv_prev;
    wire [`AOC_CNT_W-1:0]  next_since = since_rise + `AOC_CNT_ONE;
    wire                   half_hit  = (period != `AOC_CNT_ZERO) &&
                                       (next_since == {1'b0, period[`AOC_CNT_W-1:1]});
    wire                   fall_ev   = dcs_sel ? (half_hit & ~rise) : real_fall;
    wire                   edge_ev   = rise | fall_ev;

    assign stabiliser_active = dcs_sel && (period != `AOC_CNT_ZERO);

    // Period measurement between rising edges
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            conv_prev  <= 1'b0;
            since_rise <= `AOC_CNT_ZERO;
            period     <= `AOC_CNT_ZERO;
        end else begin
            conv_prev <= conv_lvl;
            if (rise) begin
                since_rise <= `AOC_CNT_ZERO;
                period     <= next_since;
            end else if (next_since != `AOC_CNT_ZERO) begin
                since_rise <= next_since;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Quantiser code handling
    // Code beyond full scale
    function automatic logic aoc_over(input logic [`AOC_RAW_W-1:0] c);
        aoc_over = ($signed(c) > $signed(`AOC_CODE_MAX)) || ($signed(c) < $signed(`AOC_CODE_MIN));
    endfunction : aoc_over

    // Clip to full scale, return offset binary
    function automatic aoc_word_t aoc_clip(input logic [`AOC_RAW_W-1:0] c);
        logic [`AOC_RAW_W-1:0] k;
        k = c;
        if ($signed(c) > $signed(`AOC_CODE_MAX)) begin
            k = `AOC_CODE_MAX;
        end else if ($signed(c) < $signed(`AOC_CODE_MIN)) begin
            k = `AOC_CODE_MIN;
        end
        aoc_clip = {~k[`AOC_MSB], k[`AOC_MSB-1:0]};
    endfunction : aoc_clip

    ////////////////////////////////////////////////////////////////////////
    // Half-cycle pipeline
    aoc_word_t pipe_data [0:`AOC_LAT_EDGES-1]; // Offset binary words
    logic [`AOC_LAT_EDGES-1:0] pipe_over;      // Over-range per stage
    logic [`AOC_LAT_EDGES-1:0] pipe_vld;       // Occupied stages
    logic                      buf_in_ready;   // Buffer has room
    wire  take  = rise && (power_state == AOC_PWR_RUN);
    wire  tail  = pipe_vld[`AOC_LAT_EDGES-1];
    wire  stall = edge_ev && tail && !buf_in_ready;
    wire  adv   = edge_ev && !stall;
    wire  buf_in_valid = edge_ev && tail;
    wire  [`AOC_DATA_W:0] buf_in_data = {pipe_over[`AOC_LAT_EDGES-1],
        pipe_data[`AOC_LAT_EDGES-1][`AOC_MSB] ^ fmt_sel,
        pipe_data[`AOC_LAT_EDGES-1][`AOC_MSB-1:0]};

    // Stage shift, one stage per convert edge
    // nine edges to the output
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pipe_vld <= '0;
            pipe_over <= '0;
            for (int i = 0; i < `AOC_LAT_EDGES; i++) begin
                pipe_data[i] <= `AOC_WORD_ZERO;
            end
        end else if (power_state == AOC_PWR_STD) begin
            pipe_vld <= '0;
        end else if (adv) begin
            pipe_vld <= {pipe_vld[`AOC_LAT_EDGES-2:0], take};
            pipe_over <= {pipe_over[`AOC_LAT_EDGES-2:0], aoc_over(quant_code)};
            pipe_data[0] <= aoc_clip(quant_code);
            for (int i = 1; i < `AOC_LAT_EDGES; i++) begin
                pipe_data[i] <= pipe_data[i-1];
            end
        end
    end

    // Pulse when the receiver stalls the pipeline
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            overrun <= 1'b0;
        end else begin
            overrun <= stall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer
    logic [`AOC_DATA_W:0] buf_out;   // Head word and flag

    aoc_buf u_buf (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .flush     (power_state == AOC_PWR_STD),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (buf_out)
    );

    assign sample_bits     = buf_out[`AOC_DATA_W-1:0];
    assign over_range_flag = buf_out[`AOC_DATA_W];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    fmt_msb_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        buf_in_valid |-> buf_in_data[`AOC_MSB] == (pipe_data[`AOC_LAT_EDGES-1][`AOC_MSB] ^ fmt_sel))
        else $error("format bit wrong");
    oe_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(oe_b) |-> !data_oe)
        else $error("drivers on while tri-stated");
    dcs_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        dcs_sel && half_hit && !rise |-> edge_ev)
        else $error("stabiliser edge missed");
    std_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        power_state == AOC_PWR_STD |=> (pipe_vld == '0) && !sample_valid)
        else $error("power-down left data");
    quasi_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        power_state != AOC_PWR_RUN |-> !take)
        else $error("sample taken in power-down");
    word_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        buf_in_valid |-> buf_in_data[`AOC_MSB-1:0] == pipe_data[`AOC_LAT_EDGES-1][`AOC_MSB-1:0])
        else $error("low bits reordered");
    stage_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        adv && power_state != AOC_PWR_STD ##1 power_state != AOC_PWR_STD |-> pipe_vld[1] == $past(pipe_vld[0]))
        else $error("pipeline skipped a stage");
    over_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        adv && take && aoc_over(quant_code) && power_state == AOC_PWR_RUN
        |=> pipe_over[0] && pipe_vld[0])
        else $error("over-range not flagged");
endmodule : aoc_top
`default_nettype wire

//--- inc/aoc_regs.svh
`ifndef AOC_REGS_SVH
`define AOC_REGS_SVH

// Word widths
`define AOC_DATA_W     12
`define AOC_RAW_W      13
`define AOC_MSB        11
// Half-cycle pipeline depth, 4.5 convert cycles as edges
`define AOC_LAT_EDGES  9
// Period counter width and one
`define AOC_CNT_W      8
`define AOC_CNT_ZERO   8'h00
`define AOC_CNT_ONE    8'h01
// Pin vector layout
`define AOC_PIN_N      6
`define AOC_PIN_CLK    0
`define AOC_PIN_OE_B   1
`define AOC_PIN_FMT    2
`define AOC_PIN_DCS    3
`define AOC_PIN_FPD    4
`define AOC_PIN_PPD    5
`define AOC_PIN_RST    6'h00
// Full-scale limits of the signed quantiser code
`define AOC_CODE_MAX   13'h07ff
`define AOC_CODE_MIN   13'h1800
`define AOC_WORD_ZERO  12'h000

`endif

//--- inc/aoc_pkg.sv
`default_nettype none
package aoc_pkg;
    // One output sample word
    typedef logic [11:0] aoc_word_t;
    // Power state of the converter
    typedef enum logic [1:0] {
        AOC_PWR_RUN   = 2'b00,
        AOC_PWR_QUASI = 2'b01,
        AOC_PWR_STD   = 2'b10
    } aoc_pwr_t;
endpackage : aoc_pkg
`default_nettype wire

//--- rtl/aoc_buf.sv
`timescale 1ns/1ns
`default_nettype none
`include "aoc_regs.svh"
module aoc_buf
    import aoc_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic                   flush,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [`AOC_DATA_W:0]   in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic      [`AOC_DATA_W:0]   out_data
);
    ////////////////////////////////////////////////////////////////////////
    logic [`AOC_DATA_W:0] mem [0:1];   // Two entries, word plus over-range
    logic                 wr_ptr;      // Next entry to fill
    logic                 rd_ptr;      // Entry at the head
    logic [1:0]           count;       // Entries held
    wire                  push = in_valid & in_ready;
    wire                  pop  = out_valid & out_ready;

    // Honest full and empty
    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];

    ////////////////////////////////////////////////////////////////////////
    // Pointers and occupancy
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            count  <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage, written at the tail
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem[0] <= {1'b0, `AOC_WORD_ZERO};
            mem[1] <= {1'b0, `AOC_WORD_ZERO};
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : aoc_buf
`default_nettype wire

//--- tb/aoc_capture.sv
`timescale 1ns/1ns
`default_nettype none
module aoc_capture
    import aoc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        hold,
    input  wire logic        sample_valid,
    input  wire logic [11:0] sample_bits,
    input  wire logic        over_range_flag,
    output logic             sample_ready
);
    // Received words, flag on top
    logic [12:0] got [$];
    // Ready unless told to stall
    assign sample_ready = ~hold;
    // Take head word on handshake
    always @(posedge clk_sys) begin
        if (rst_b && sample_valid === 1'b1 && sample_ready) begin
            got.push_back({over_range_flag, sample_bits});
        end
    end
endmodule : aoc_capture
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "aoc_regs.svh"
module tb_top
    import aoc_pkg::*;
;
    logic                  clk_sys, rst_b, convert_clock, output_enable_b;
    logic                  code_format_select, duty_cycle_stabiliser;
    logic                  full_power_down, partial_power_down, hold;
    logic [`AOC_RAW_W-1:0] quant_code;
    logic [11:0]           sample_bits;
    logic                  over_range_flag, data_oe, sample_valid, sample_ready;
    logic                  overrun, stabiliser_active, stall_seen;
    aoc_pwr_t              power_state;
    int                    fail_count, checks_done, i;
    // Stimulus codes: zero, limits, over both ways, mid
    logic [12:0]           codes [6] = '{13'h0000, 13'h07ff, 13'h1800, 13'h0900, 13'h1000, 13'h0123};

    aoc_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .convert_clock(convert_clock),
        .output_enable_b(output_enable_b), .code_format_select(code_format_select),
        .duty_cycle_stabiliser(duty_cycle_stabiliser), .full_power_down(full_power_down),
        .partial_power_down(partial_power_down), .quant_code(quant_code), .sample_bits(sample_bits),
        .over_range_flag(over_range_flag), .data_oe(data_oe), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .overrun(overrun), .power_state(power_state),
        .stabiliser_active(stabiliser_active));
    aoc_capture cap (.clk_sys(clk_sys), .rst_b(rst_b), .hold(hold), .sample_valid(sample_valid),
        .sample_bits(sample_bits), .over_range_flag(over_range_flag), .sample_ready(sample_ready));

    ////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Remember any stall pulse
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) stall_seen <= 1'b0;
        else if (overrun === 1'b1) stall_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Expected word: clip, flag, offset or two's complement
    function automatic logic [12:0] exp_of(input logic [12:0] c, input logic f);
        logic [12:0] r;
        if ($signed(c) > $signed(13'h07ff)) r = 13'h17ff;
        else if ($signed(c) < $signed(13'h1800)) r = 13'h1800;
        else r = {1'b0, c[11:0]};
        return f ? r : (r ^ 13'h0800);
    endfunction : exp_of
    task automatic chk(input string name, input logic [12:0] e, input logic [12:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk
    // One convert period of 8 cycles, hi cycles high
    task automatic conv(input logic [12:0] c, input int hi);
        convert_clock = 1'b1;
        wait_clk(2);
        quant_code = c;
        wait_clk(hi - 2);
        convert_clock = 1'b0;
        wait_clk(8 - hi);
    endtask : conv
    // Empty pipeline and buffer by full power-down
    task automatic clean;
        full_power_down = 1'b1;
        wait_clk(8);
        full_power_down = 1'b0;
        wait_clk(6);
        cap.got.delete();
    endtask : clean
    // Stream of codes, then flush periods, compare in order
    task automatic run_set(input logic f, input int hi);
        code_format_select = f;
        clean();
        for (int k = 0; k < 6; k++) conv(codes[k], hi);
        for (int k = 0; k < 5; k++) conv(13'h0000, hi);
        for (int k = 0; k < 6; k++) begin
            chk("word", exp_of(codes[k], f), (cap.got.size() > k) ? cap.got[k] : 13'bx);
        end
    endtask : run_set
    task automatic complete_run;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // Hang guard
    initial begin
        #3000000;
        fail_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_b, convert_clock, output_enable_b, code_format_select, hold} = 5'h00;
        {duty_cycle_stabiliser, full_power_down, partial_power_down} = 3'h0;
        quant_code = 13'h0000;
        wait_clk(10);
        rst_b = 1'b1;
        wait_clk(6);
        chk("data_oe", 13'h0001, 13'(data_oe));
        output_enable_b = 1'b1;
        wait_clk(6);
        chk("data_oe off", 13'h0000, 13'(data_oe));
        output_enable_b = 1'b0;
        run_set(1'b0, 4);
        run_set(1'b1, 4);
        // Result 4.5 convert periods after its rise
        clean();
        conv(13'h0123, 4);
        for (i = 0; i < 3; i++) conv(13'h0000, 4);
        // Eighth edge passed, ninth not yet
        convert_clock = 1'b1;
        wait_clk(8);
        chk("early count", 13'h0000, 13'(cap.got.size()));
        convert_clock = 1'b0;
        wait_clk(8);
        chk("due count", 13'h0001, 13'(cap.got.size()));
        // Quasi power-down takes no samples
        clean();
        partial_power_down = 1'b1;
        wait_clk(6);
        chk("quasi state", 13'(AOC_PWR_QUASI), 13'(power_state));
        for (i = 0; i < 6; i++) conv(13'h0123, 4);
        chk("quasi count", 13'h0000, 13'(cap.got.size()));
        // Full power-down wins over partial
        full_power_down = 1'b1;
        wait_clk(6);
        chk("std state", 13'(AOC_PWR_STD), 13'(power_state));
        chk("std data_oe", 13'h0000, 13'(data_oe));
        for (i = 0; i < 6; i++) conv(13'h0123, 4);
        chk("std count", 13'h0000, 13'(cap.got.size()));
        {full_power_down, partial_power_down} = 2'b00;
        wait_clk(6);
        chk("run state", 13'(AOC_PWR_RUN), 13'(power_state));
        // Stabiliser on, 37.5 percent duty in range
        // supplier duty
        duty_cycle_stabiliser = 1'b1;
        run_set(1'b1, 3);
        chk("stabiliser", 13'h0001, 13'(stabiliser_active));
        duty_cycle_stabiliser = 1'b0;
        wait_clk(6);
        chk("stabiliser off", 13'h0000, 13'(stabiliser_active));
        // Receiver stalls: buffer fills, nothing reordered
        clean();
        hold = 1'b1;
        for (i = 0; i < 8; i++) conv(codes[i % 6], 4);
        chk("valid held", 13'h0001, 13'(sample_valid));
        chk("overrun", 13'h0001, 13'(stall_seen));
        hold = 1'b0;
        for (i = 0; i < 5; i++) conv(13'h0000, 4);
        chk("stall first", exp_of(codes[0], 1'b1), (cap.got.size() > 0) ? cap.got[0] : 13'h1fff);
        chk("stall second", exp_of(codes[1], 1'b1), (cap.got.size() > 1) ? cap.got[1] : 13'h1fff);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
